// ==== rtl/pmt_cfg.svh ====
`ifndef PMT_CFG_SVH
`define PMT_CFG_SVH
// Operation
// - timer clock is the instruction clock, master clock divided by four.
// - prescale code 00/01/10/11 divides by 1/4/16/64 before counting.
// - count compared with period on every prescaler output; equality gives match output.
// - after a match the count returns to zero instead of incrementing.
// - count and period registers readable and writable at any time.
// - reset clears the count and sets the period to all ones.
// - count write, control write and reset clear prescaler and postscaler.
// - control write leaves the count unchanged.
// - matches advance 4-bit postscaler whose output sets sticky match flag.
// - interrupt requested from the flag only while match enable is set.
// - postscale field value plus one matches per flag, 1:1 to 1:16.
// - unscaled match exported to capture/compare/PWM units as time base.
// - timer output offered as shift clock for serial port in SPI mode.
// - in sleep the timer does not count; count and period held.
// - control bit 7 reads zero; postscale bits 6-3, prescale bits 1-0.
// - one counter cycle spans period value plus one prescaler outputs.

// =====================================================================
// register map
`define PMT_ADDR_COUNT   3'h0
`define PMT_ADDR_PERIOD  3'h1
`define PMT_ADDR_CTRL    3'h2
`define PMT_ADDR_FLAG    3'h3
`define PMT_ADDR_ENABLE  3'h4

// =====================================================================
// reset values and fields
`define PMT_COUNT_RST    8'h00
`define PMT_PERIOD_RST   8'hff
`define PMT_CTRL_RST     7'h00
`define PMT_CTRL_ON_BIT  2
`define PMT_POST_MSB     6
`define PMT_POST_LSB     3
`define PMT_PRE_MSB      1
`define PMT_PRE_LSB      0

// =====================================================================
// timing
`define PMT_INSTR_DIV_LAST 2'h3
`define PMT_PRE_LAST_1     6'h00
`define PMT_PRE_LAST_4     6'h03
`define PMT_PRE_LAST_16    6'h0f
`define PMT_PRE_LAST_64    6'h3f
`endif

// ==== rtl/pmt_pkg.sv ====
package pmt_pkg;
  typedef struct packed {
    logic [5:0] cnt;
  } pmt_pre_state_t;

  typedef struct packed {
    logic [3:0] cnt;
  } pmt_post_state_t;

  typedef struct packed {
    logic [1:0] div;
    logic [7:0] count;
    logic [7:0] period;
    logic [6:0] ctrl;
    logic       flag;
    logic       enable;
    logic [7:0] rdata;
    logic       match;
    logic       spi_clk;
    logic       irq;
  } pmt_top_state_t;
endpackage

// ==== rtl/pmt_postscaler.sv ====
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_postscaler
  import pmt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       match,
  input  wire logic [3:0] sel,
  output logic            fire
);
  pmt_post_state_t st_ff;
  pmt_post_state_t nxt_st;

  // =====================================================================
  // match counter
  always_comb begin
    fire = match && !clr && (st_ff.cnt >= sel);
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.cnt = 4'h0;
    end else if (match) begin
      nxt_st.cnt = fire ? 4'h0 : st_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  AST_POST_RATIO: assert property (@(posedge clk) disable iff (!rst_n)
    ce && match && !clr && st_ff.cnt < sel |-> !fire) else $error("postscaler early");
endmodule // pmt_postscaler

// ==== rtl/pmt_prescaler.sv ====
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_prescaler
  import pmt_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       ce,
  input  wire logic       clr,
  input  wire logic       tick,
  input  wire logic [1:0] sel,
  output logic            inc
);
  pmt_pre_state_t st_ff;
  pmt_pre_state_t nxt_st;
  logic [5:0]     last;

  // =====================================================================
  // divider
  always_comb begin
    unique case (sel)
      2'h0: last = `PMT_PRE_LAST_1;
      2'h1: last = `PMT_PRE_LAST_4;
      2'h2: last = `PMT_PRE_LAST_16;
      2'h3: last = `PMT_PRE_LAST_64;
    endcase
    inc = tick && !clr && (st_ff.cnt >= last);
    nxt_st = st_ff;
    if (clr) begin
      nxt_st.cnt = 6'h00;
    end else if (tick) begin
      // a shrunk ratio with a count above the new limit wraps at once
      nxt_st.cnt = inc ? 6'h00 : st_ff.cnt + 6'h01;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= '0;
    end else if (ce) begin
      st_ff <= nxt_st;
    end
  end

  AST_PRE_CLEAR: assert property (@(posedge clk) disable iff (!rst_n)
    ce && clr |=> st_ff.cnt == 6'h00) else $error("prescaler not cleared");
endmodule // pmt_prescaler

// ==== rtl/pmt_top.sv ====
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module pmt_top
  import pmt_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RESET_N,
  input  wire logic       CLK_EN,
  input  wire logic       SLEEP,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic            MATCH_OUT,
  output logic            SPI_SHIFT_CLK,
  output logic            IRQ
);
  pmt_top_state_t st_ff;
  pmt_top_state_t nxt_st;
  logic           tick;
  logic           timer_on;
  logic           clr_scalers;
  logic           inc;
  logic           match_evt;
  logic           fire;
  logic           wr_count;
  logic           wr_period;
  logic           wr_ctrl;
  logic           wr_flag;
  logic           wr_enable;

  // =====================================================================
  // decode
  assign wr_count  = WR && (ADDR == `PMT_ADDR_COUNT);
  assign wr_period = WR && (ADDR == `PMT_ADDR_PERIOD);
  assign wr_ctrl   = WR && (ADDR == `PMT_ADDR_CTRL);
  assign wr_flag   = WR && (ADDR == `PMT_ADDR_FLAG);
  assign wr_enable = WR && (ADDR == `PMT_ADDR_ENABLE);

  assign timer_on    = st_ff.ctrl[`PMT_CTRL_ON_BIT];
  // sleep stops the instruction clock itself, so nothing downstream moves
  assign tick        = (st_ff.div == `PMT_INSTR_DIV_LAST) && !SLEEP && timer_on;
  assign clr_scalers = wr_count || wr_ctrl;

  // match is only judged on a prescaler output, the cycle the count would step
  assign match_evt = inc && (st_ff.count == st_ff.period);

  // =====================================================================
  // scalers
  pmt_prescaler u_pre (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .clr   (clr_scalers),
    .tick  (tick),
    .sel   (st_ff.ctrl[`PMT_PRE_MSB:`PMT_PRE_LSB]),
    .inc   (inc)
  );

  pmt_postscaler u_post (
    .clk   (MCLK),
    .rst_n (RESET_N),
    .ce    (CLK_EN),
    .clr   (clr_scalers),
    .match (match_evt),
    .sel   (st_ff.ctrl[`PMT_POST_MSB:`PMT_POST_LSB]),
    .fire  (fire)
  );

  // =====================================================================
  // next state
  always_comb begin
    nxt_st = st_ff;
    if (!SLEEP) begin
      nxt_st.div = st_ff.div + 2'h1;
    end

    if (wr_count) begin
      nxt_st.count = WDATA;
    end else if (match_evt) begin
      nxt_st.count = `PMT_COUNT_RST;
    end else if (inc) begin
      nxt_st.count = st_ff.count + 8'h01;
    end

    if (wr_period) begin
      nxt_st.period = WDATA;
    end
    if (wr_ctrl) begin
      nxt_st.ctrl = WDATA[6:0];
    end
    if (wr_enable) begin
      nxt_st.enable = WDATA[0];
    end

    // a postscaler event in the clearing cycle wins over the clear
    if (fire) begin
      nxt_st.flag = 1'b1;
    end else if (wr_flag && WDATA[0]) begin
      nxt_st.flag = 1'b0;
    end

    nxt_st.rdata = 8'h00;
    if (RD) begin
      unique case (ADDR)
        `PMT_ADDR_COUNT:  nxt_st.rdata = st_ff.count;
        `PMT_ADDR_PERIOD: nxt_st.rdata = st_ff.period;
        `PMT_ADDR_CTRL:   nxt_st.rdata = {1'b0, st_ff.ctrl};
        `PMT_ADDR_FLAG:   nxt_st.rdata = {7'h00, st_ff.flag};
        `PMT_ADDR_ENABLE: nxt_st.rdata = {7'h00, st_ff.enable};
        default:          nxt_st.rdata = 8'h00;
      endcase
    end

    nxt_st.match = match_evt;
    if (match_evt) begin
      nxt_st.spi_clk = !st_ff.spi_clk;
    end
    nxt_st.irq = st_ff.flag && st_ff.enable;
  end

  // =====================================================================
  // state register
  always_ff @(posedge MCLK or negedge RESET_N) begin
    if (!RESET_N) begin
      st_ff        <= '0;
      st_ff.count  <= `PMT_COUNT_RST;
      st_ff.period <= `PMT_PERIOD_RST;
      st_ff.ctrl   <= `PMT_CTRL_RST;
    end else if (CLK_EN) begin
      st_ff <= nxt_st;
    end
  end

  assign RDATA         = st_ff.rdata;
  assign MATCH_OUT     = st_ff.match;
  assign SPI_SHIFT_CLK = st_ff.spi_clk;
  assign IRQ           = st_ff.irq;

  // =====================================================================
  // checks
  AST_TICK_SPACING: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && tick |=> !tick) else $error("timer clock faster than quarter rate");

  AST_PRE_BYPASS: assert property (@(posedge MCLK) disable iff (!RESET_N)
    st_ff.ctrl[1:0] == 2'h0 && !clr_scalers |-> inc == tick)
    else $error("prescale 1 not direct");

  AST_MATCH_EQUAL: assert property (@(posedge MCLK) disable iff (!RESET_N)
    match_evt |-> st_ff.count == st_ff.period) else $error("match without equality");

  AST_MATCH_WRAP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && match_evt && !wr_count |=> st_ff.count == 8'h00 && MATCH_OUT)
    else $error("count not zero after match");

  AST_COUNT_WRITE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_count |=> st_ff.count == $past(WDATA)) else $error("count write lost");

  AST_RESET_VALUES: assert property (@(posedge MCLK)
    $rose(RESET_N) |-> st_ff.count == 8'h00 && st_ff.period == 8'hff)
    else $error("bad reset values");

  AST_CTRL_KEEPS_COUNT: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_ctrl |=> $stable(st_ff.count)) else $error("control write moved count");

  AST_FLAG_STICKY: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && st_ff.flag && !wr_flag |=> st_ff.flag) else $error("flag dropped");

  AST_IRQ_GATED: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !st_ff.enable && !wr_enable |=> ##1 !IRQ) else $error("masked irq");

  AST_SLEEP_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && SLEEP && !WR |=> $stable(st_ff.count) && $stable(st_ff.period))
    else $error("timer moved in sleep");

  AST_OFF_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !timer_on && !wr_count |=> $stable(st_ff.count)) else $error("count while off");

  AST_CTRL_TOP_ZERO: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_CTRL |=> RDATA[7] == 1'b0)
    else $error("control bit 7 set");

  // =====================================================================
  // checks: timer clock, scalers and sleep
  // no helper flops here: every window is written with $past so that
  // the module keeps all of its state in the one struct
  AST_DIV_STEP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !SLEEP |=> st_ff.div == $past(st_ff.div) + 2'h1)
    else $error("instruction divider skipped a step");

  AST_DIV_SLEEP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && SLEEP |=> $stable(st_ff.div))
    else $error("instruction divider ran in sleep");

  AST_FREEZE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !CLK_EN |=> $stable(st_ff))
    else $error("state moved with clock enable low");

  AST_TICK_PHASE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    tick |-> st_ff.div == `PMT_INSTR_DIV_LAST)
    else $error("timer clock off its quarter phase");

  AST_TICK_SLEEP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    SLEEP |-> !tick)
    else $error("timer clock in sleep");

  AST_TICK_OFF: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !timer_on |-> !tick)
    else $error("timer clock while off");

  AST_INC_NEEDS_TICK: assert property (@(posedge MCLK) disable iff (!RESET_N)
    inc |-> tick)
    else $error("increment without timer clock");

  AST_CLR_NO_INC: assert property (@(posedge MCLK) disable iff (!RESET_N)
    clr_scalers |-> !inc && !fire)
    else $error("scaler output in clearing cycle");

  AST_MATCH_NEEDS_INC: assert property (@(posedge MCLK) disable iff (!RESET_N)
    match_evt |-> inc)
    else $error("match outside a timer clock");

  AST_MATCH_DUE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    inc && st_ff.count == st_ff.period |-> match_evt)
    else $error("equality missed");

  AST_SLEEP_NO_MATCH: assert property (@(posedge MCLK) disable iff (!RESET_N)
    SLEEP |-> !match_evt && !fire)
    else $error("match in sleep");

  AST_OFF_NO_FIRE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    !timer_on |-> !match_evt && !fire)
    else $error("match while off");

  AST_FIRE_ON_MATCH: assert property (@(posedge MCLK) disable iff (!RESET_N)
    fire |-> match_evt)
    else $error("postscaler fired without match");

  AST_FIRE_1TO1: assert property (@(posedge MCLK) disable iff (!RESET_N)
    match_evt && !clr_scalers && st_ff.ctrl[`PMT_POST_MSB:`PMT_POST_LSB] == 4'h0
    |-> fire)
    else $error("1:1 postscale missed a match");

  // =====================================================================
  // checks: count, period and control registers
  AST_COUNT_STEP: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && inc && !match_evt && !wr_count |=> st_ff.count == $past(st_ff.count) + 8'h01)
    else $error("count did not step");

  AST_COUNT_IDLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !inc && !wr_count |=> $stable(st_ff.count))
    else $error("count moved without increment");

  AST_PERIOD_WRITE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_period |=> st_ff.period == $past(WDATA))
    else $error("period write lost");

  AST_PERIOD_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !wr_period |=> $stable(st_ff.period))
    else $error("period moved without write");

  AST_CTRL_WRITE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_ctrl |=> st_ff.ctrl == $past(WDATA[6:0]))
    else $error("control write lost");

  AST_CTRL_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !wr_ctrl |=> $stable(st_ff.ctrl))
    else $error("control moved without write");

  AST_ENABLE_WRITE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_enable |=> st_ff.enable == $past(WDATA[0]))
    else $error("enable write lost");

  AST_WRITE_UNMAPPED: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && WR && ADDR > `PMT_ADDR_ENABLE
    |=> $stable(st_ff.period) && $stable(st_ff.ctrl) && $stable(st_ff.enable))
    else $error("unmapped write changed a register");

  // =====================================================================
  // checks: outputs, flag and read data
  AST_MATCH_PULSE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !match_evt |=> !MATCH_OUT)
    else $error("match output without match");

  AST_SPI_TOGGLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && match_evt |=> SPI_SHIFT_CLK != $past(SPI_SHIFT_CLK))
    else $error("shift clock missed a match");

  AST_SPI_HOLD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !match_evt |=> $stable(SPI_SHIFT_CLK))
    else $error("shift clock moved without match");

  AST_FLAG_SET: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && fire |=> st_ff.flag)
    else $error("flag not set by postscaler");

  AST_FLAG_CLEAR: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && wr_flag && WDATA[0] && !fire |=> !st_ff.flag)
    else $error("flag not cleared by write");

  AST_FLAG_SOURCE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !st_ff.flag && !fire |=> !st_ff.flag)
    else $error("flag set without postscaler");

  AST_IRQ_SET: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && st_ff.flag && st_ff.enable |=> IRQ)
    else $error("enabled flag without irq");

  AST_IRQ_LOW: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !(st_ff.flag && st_ff.enable) |=> !IRQ)
    else $error("irq without enabled flag");

  AST_RDATA_IDLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && !RD |=> RDATA == 8'h00)
    else $error("read data without read");

  AST_READ_COUNT: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_COUNT |=> RDATA == $past(st_ff.count))
    else $error("count read wrong");

  AST_READ_PERIOD: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_PERIOD |=> RDATA == $past(st_ff.period))
    else $error("period read wrong");

  AST_READ_CTRL: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_CTRL |=> RDATA == {1'b0, $past(st_ff.ctrl)})
    else $error("control read wrong");

  AST_READ_FLAG: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_FLAG |=> RDATA == {7'h00, $past(st_ff.flag)})
    else $error("flag read wrong");

  AST_READ_ENABLE: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR == `PMT_ADDR_ENABLE |=> RDATA == {7'h00, $past(st_ff.enable)})
    else $error("enable read wrong");

  AST_READ_UNMAPPED: assert property (@(posedge MCLK) disable iff (!RESET_N)
    CLK_EN && RD && ADDR > `PMT_ADDR_ENABLE |=> RDATA == 8'h00)
    else $error("unmapped read not zero");

  COV_MATCH: cover property (@(posedge MCLK) disable iff (!RESET_N) match_evt);
  COV_FLAG:  cover property (@(posedge MCLK) disable iff (!RESET_N) fire ##1 st_ff.flag);
  COV_IRQ:   cover property (@(posedge MCLK) disable iff (!RESET_N) $rose(IRQ));
  COV_SLEEP: cover property (@(posedge MCLK) disable iff (!RESET_N) timer_on && SLEEP);
  COV_FREEZE: cover property (@(posedge MCLK) disable iff (!RESET_N) timer_on && !CLK_EN);
endmodule // pmt_top

// ==== verif/period_match_timer8_tb.sv ====
`timescale 1ns/1ps
`include "pmt_cfg.svh"
module period_match_timer8_tb
  import pmt_pkg::*;
;
  // =====================================================
  // stimulus, design and register model
  logic       mclk;
  logic       reset_n;
  logic       clk_en;
  logic       sleep;
  logic       wr;
  logic       rd;
  logic [2:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       match_out;
  logic       spi_clk;
  logic       irq;
  logic [7:0] d;
  logic [7:0] c;
  int         err_count;
  int         n_compared;
  int         seed;
  int         t;
  int         m;
  int         p;
  int         mdl [8];

  always #25 mclk = ~mclk;

  pmt_top i_pmt_top (
    .MCLK          (mclk),
    .RESET_N       (reset_n),
    .CLK_EN        (clk_en),
    .SLEEP         (sleep),
    .ADDR          (addr),
    .WDATA         (wdata),
    .WR            (wr),
    .RD            (rd),
    .RDATA         (rdata),
    .MATCH_OUT     (match_out),
    .SPI_SHIFT_CLK (spi_clk),
    .IRQ           (irq)
  );

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    mdl = '{0, 'hff, 0, 0, 0, 0, 0, 0};
  endtask

  // the model is compared only for registers that software alone changes
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
    @(posedge mclk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge mclk);
    wr <= 1'b0;
    if (a == 3'h2) mdl[2] = v & 8'h7f;
    else if (a == 3'h4) mdl[4] = v & 8'h01;
    else if (a < 3'h2) mdl[a] = v;
  endtask

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
    @(posedge mclk);
    rd <= 1'b1;
    addr <= a;
    @(posedge mclk);
    rd <= 1'b0;
    #1 v = rdata;
    if (a != 3'h0 && a != 3'h3) check("reg", v, mdl[a]);
  endtask

  task automatic wait_match(output int n);
    logic s;
    n = 0;
    do begin
      s = spi_clk;
      @(posedge mclk);
      #1 n++;
    end while (match_out !== 1'b1 && n < 20000);
    check("spi_toggle", spi_clk ^ s, 1);
  endtask

  // =====================================================
  // watchdog: the whole sequence needs well under this
  initial begin
    repeat (90000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  // =====================================================
  // main sequence
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    clk_en = 1'b1;
    sleep = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    err_count = 0;
    n_compared = 0;
    seed = 18234;
    do_reset();
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[2:0], d);
      if (a == 0 || a == 3) check("rst_val", d, 0);
    end
    wr_reg(3'h5, 8'h5a);
    rd_reg(3'h5, d);
    c = $random(seed);
    wr_reg(3'h0, c);
    wr_reg(3'h1, $random(seed));
    rd_reg(3'h1, d);
    wr_reg(3'h2, 8'hfb);
    rd_reg(3'h2, d);
    rd_reg(3'h0, d);
    check("count_keep", d, c);
    for (int k = 0; k < 4; k++) begin
      p = $random(seed) & 7;
      wr_reg(3'h1, p[7:0]);
      // start below the new period, else a slow ratio waits for a full 8-bit wrap
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h2, {5'h01, k[1:0]});
      wait_match(t);
      wait_match(t);
      check("interval", t, 4 * (1 << (2 * k)) * (p + 1));
      if (k == 3) rd_reg(3'h0, d);
      if (k == 3) check("count_wrap", d, 0);
    end
    // a stale prescaler residue would shorten this by several ticks
    p = 2;
    wr_reg(3'h1, 8'h02);
    wr_reg(3'h2, 8'h05);
    wait_match(t);
    repeat (10) @(posedge mclk);
    wr_reg(3'h0, 8'h00);
    wait_match(t);
    check("presc_clr", t >= 16 * (p + 1) - 3 && t <= 16 * (p + 1) + 1, 1);
    // frozen cycles add nothing; the edge that launches the freeze still counts
    @(posedge mclk);
    clk_en <= 1'b0;
    repeat (20) @(posedge mclk);
    clk_en <= 1'b1;
    wait_match(t);
    check("clk_en_freeze", t, 16 * (p + 1) - 1);
    for (int n = 0; n < 16; n++) begin
      p = $random(seed) & 1;
      wr_reg(3'h2, 8'h00);
      wr_reg(3'h0, 8'h00);
      wr_reg(3'h1, p[7:0]);
      wr_reg(3'h3, 8'h01);
      wr_reg(3'h4, 8'h01);
      wr_reg(3'h2, {1'b0, n[3:0], 3'b100});
      m = 0;
      t = 0;
      do begin
        @(posedge mclk);
        #1 t++;
        m += int'(match_out);
      end while (irq !== 1'b1 && t < 3000);
      check("post_ratio", m, n + 1);
      check("post_irq", irq, 1);
    end
    wr_reg(3'h4, 8'h00);
    repeat (2) @(posedge mclk);
    #1;
    check("irq_masked", irq, 0);
    rd_reg(3'h3, d);
    check("flag_sticky", d[0], 1);
    wr_reg(3'h2, 8'h00);
    wr_reg(3'h3, 8'h01);
    rd_reg(3'h3, d);
    check("flag_clr", d[0], 0);
    wr_reg(3'h1, 8'hff);
    wr_reg(3'h2, 8'h04);
    sleep <= 1'b1;
    rd_reg(3'h0, c);
    repeat (40) @(posedge mclk);
    rd_reg(3'h0, d);
    check("sleep_hold", d, c);
    rd_reg(3'h1, d);
    sleep <= 1'b0;
    repeat (40) @(posedge mclk);
    rd_reg(3'h0, d);
    check("run_again", d != c, 1);
    do_reset();
    rd_reg(3'h0, d);
    check("rst_count", d, 0);
    rd_reg(3'h1, d);
    rd_reg(3'h2, d);
    end_sim();
  end
endmodule // period_match_timer8_tb
